//--- include/pic_pkg.sv
// Shared constants and types of the paged I2C control port
`default_nettype none
package pic_pkg;
  typedef logic [7:0] pic_byte_t;
  typedef logic [6:0] pic_off_t;
  // Device addressing and paged space
  localparam logic [4:0] CHIP_ADDR_HI = 5'h12;
  localparam pic_off_t PAGE_IND_OFF = 7'h00;
  localparam pic_off_t DBNC_OFF = 7'h01;
  localparam pic_byte_t PAGE_RESET = 8'h00;
  localparam pic_byte_t REG_RESET = 8'h00;
  localparam int PAGE_SEL_BITS = 1;
  localparam int REG_IDX_W = PAGE_SEL_BITS + 7;
  localparam int REG_COUNT = 1 << REG_IDX_W;
  localparam logic PATH_I2C = 1'h0;
  // Speed modes in the debounce register and their glitch filter lengths
  localparam logic [1:0] MODE_SM = 2'h0;
  localparam logic [1:0] MODE_FM = 2'h1;
  localparam int FILT_W = 3;
  localparam logic [FILT_W-1:0] FILT_SM = 3'h4;
  localparam logic [FILT_W-1:0] FILT_FM = 3'h2;
  localparam logic [FILT_W-1:0] FILT_FMP = 3'h1;
  // Host timing
  localparam int CLK_FREQ_HZ = 125_000_000;
  localparam int POWERUP_WAIT_US = 1000;
  localparam int POWERUP_WAIT_CYCLES = POWERUP_WAIT_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int SM_BIT_RATE = 100_000;
  localparam logic [15:0] QUARTER_SM =
    16'((CLK_FREQ_HZ + 4 * SM_BIT_RATE - 1) / (4 * SM_BIT_RATE));
  // Host registers on the bus
  localparam int HOST_AW = 8;
  localparam logic [7:0] HOST_CMD_OFF = 8'h00;
  localparam logic [7:0] HOST_STAT_OFF = 8'h04;
  localparam logic [7:0] HOST_DIV_OFF = 8'h08;
  localparam int CMD_START_BIT = 8;
  localparam int CMD_STOP_BIT = 9;
  localparam int CMD_READ_BIT = 10;
  localparam int CMD_NACK_BIT = 11;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_RX_LSB = 8;
  localparam int STAT_PWR_BIT = 16;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [2:0] {
    D_IDLE, D_ADDR, D_MAP, D_WDATA, D_RXACK, D_RDATA, D_RACK
  } pic_dev_state_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} pic_host_state_t;
endpackage : pic_pkg
`default_nettype wire

//--- include/pic_if.sv
// Two-wire link between host and device ends, open drain with pull-up
`default_nettype none
interface pic_if;
  logic host_scl_out;
  logic host_scl_oe_n;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;
  // Wired-AND with pull-up: a released line reads high
  assign scl = host_scl_oe_n | host_scl_out;
  assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);
  modport host (
    output host_scl_out, host_scl_oe_n, host_sda_out, host_sda_oe_n,
    input scl, sda
  );
  modport device (
    output dev_sda_out, dev_sda_oe_n,
    input scl, sda
  );
endinterface : pic_if
`default_nettype wire

//--- rtl/pic_sync.sv
// Two flip-flop synchroniser for levels entering a clock domain
`default_nettype none
module pic_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    meta_reg <= d_i;
    q_o <= meta_reg;
  end
endmodule : pic_sync
`default_nettype wire

//--- rtl/pic_device.sv
// Paged I2C control port: device end with its paged register space
//
// Implementation choice: register writes leave on a core-clock strobe port.
`default_nettype none
module pic_device (
  input wire logic link_clk_i,
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic control_path_select_i,
  input wire logic address_strap_lsb_i,
  input wire logic address_strap_msb_i,
  pic_if.device link,
  output var pic_pkg::pic_byte_t wr_page_o,
  output var pic_pkg::pic_off_t wr_offset_o,
  output var pic_pkg::pic_byte_t wr_data_o,
  output logic wr_strobe_o
);
  import pic_pkg::*;

  logic [5:0] pins_s;
  logic link_rst;
  logic scl_s;
  logic sda_s;
  logic sel_s;
  logic [1:0] strap_s;
  logic [1:0] raw_s;
  logic [1:0] filt_reg;
  logic [FILT_W-1:0] fcnt_reg [2];
  logic [FILT_W-1:0] filt_len;
  logic [1:0] speed_mode;
  logic scl_f;
  logic sda_f;
  logic scl_q_reg;
  logic sda_q_reg;
  logic start_ev;
  logic stop_ev;
  logic rise_ev;
  logic fall_ev;
  logic strap_ok_reg;
  logic [1:0] strap_reg;
  logic i2c_en_reg;
  pic_dev_state_t st_reg;
  pic_dev_state_t after_reg;
  logic [2:0] bcnt_reg;
  logic last_bit;
  pic_byte_t sh_reg;
  pic_byte_t sh_next;
  pic_byte_t tx_reg;
  logic sda_oe_n_reg;
  logic addr_hit;
  logic rx_state;
  logic addr_done;
  logic map_done;
  logic wr_done;
  logic rd_done;
  pic_off_t ptr_reg;
  logic auto_increment_flag_reg;
  pic_byte_t page_reg;
  pic_byte_t regs_reg [REG_COUNT];
  logic [REG_IDX_W-1:0] reg_idx;
  pic_byte_t rd_byte;
  pic_byte_t h_page_reg;
  pic_off_t h_off_reg;
  pic_byte_t h_data_reg;
  logic h_tgl_reg;
  logic core_tgl_s;
  logic core_tgl_q_reg;

  // Reset, lines and straps all arrive from outside the link domain
  pic_sync #(.WIDTH(6)) u_link_sync (
    .clk_i(link_clk_i),
    .d_i({reset_i, link.scl, link.sda, control_path_select_i,
          address_strap_msb_i, address_strap_lsb_i}),
    .q_o(pins_s)
  );
  assign {link_rst, scl_s, sda_s, sel_s, strap_s} = pins_s;

  // Filter length follows the speed mode held in page 0
  assign speed_mode = regs_reg[REG_IDX_W'(DBNC_OFF)][1:0];
  assign filt_len = (speed_mode == MODE_SM) ? FILT_SM :
                    (speed_mode == MODE_FM) ? FILT_FM : FILT_FMP;
  assign raw_s = {scl_s, sda_s};

  // Glitch filter per line: a new level must persist filt_len samples
  for (genvar i = 0; i < 2; i++) begin : g_filt
    always_ff @(posedge link_clk_i) begin
      if (link_rst) begin
        filt_reg[i] <= 1'h1;
        fcnt_reg[i] <= '0;
      end else if (raw_s[i] == filt_reg[i]) begin
        fcnt_reg[i] <= '0;
      end else if (FILT_W'(fcnt_reg[i] + 1'h1) >= filt_len) begin
        filt_reg[i] <= raw_s[i];
        fcnt_reg[i] <= '0;
      end else begin
        fcnt_reg[i] <= FILT_W'(fcnt_reg[i] + 1'h1);
      end
    end
  end
  assign scl_f = filt_reg[1];
  assign sda_f = filt_reg[0];

  // Previous filtered levels for edge and condition detection
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      scl_q_reg <= 1'h1;
      sda_q_reg <= 1'h1;
    end else begin
      scl_q_reg <= scl_f;
      sda_q_reg <= sda_f;
    end
  end

  // SDA moving while SCL stays high marks Start or Stop
  assign start_ev = scl_f && scl_q_reg && sda_q_reg && !sda_f;
  assign stop_ev = scl_f && scl_q_reg && !sda_q_reg && sda_f;
  assign rise_ev = scl_f && !scl_q_reg;
  assign fall_ev = !scl_f && scl_q_reg;

  // Straps and path select caught once, right after reset release
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      strap_ok_reg <= 1'h0;
      strap_reg <= 2'h0;
      i2c_en_reg <= 1'h0;
    end else if (!strap_ok_reg) begin
      strap_ok_reg <= 1'h1;
      strap_reg <= strap_s;
      i2c_en_reg <= (sel_s == PATH_I2C);
    end
  end

  // Byte decode on the rising edge that brings in the eighth bit
  assign sh_next = {sh_reg[6:0], sda_f};
  assign last_bit = (bcnt_reg == 3'h7);
  assign rx_state = (st_reg == D_ADDR) || (st_reg == D_MAP) || (st_reg == D_WDATA);
  assign addr_hit = (sh_next[7:3] == CHIP_ADDR_HI) && (sh_next[2:1] == strap_reg);
  assign addr_done = rise_ev && (st_reg == D_ADDR) && last_bit;
  assign map_done = rise_ev && (st_reg == D_MAP) && last_bit;
  assign wr_done = rise_ev && (st_reg == D_WDATA) && last_bit;
  assign rd_done = rise_ev && (st_reg == D_RDATA) && last_bit;

  // Register index: low page bits select the bank, offset within it
  assign reg_idx = {page_reg[PAGE_SEL_BITS-1:0], ptr_reg};
  assign rd_byte = (ptr_reg == PAGE_IND_OFF) ? page_reg : regs_reg[reg_idx];

  // Receive shifter
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      sh_reg <= 8'h00;
    end else if (rise_ev && rx_state) begin
      sh_reg <= sh_next;
    end
  end

  // Pointer survives Stop, so a pointer-only write presets reads
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      ptr_reg <= PAGE_IND_OFF;
      auto_increment_flag_reg <= 1'h0;
    end else if (map_done) begin
      ptr_reg <= sh_next[6:0];
      auto_increment_flag_reg <= sh_next[7];
    end else if ((wr_done || rd_done) && auto_increment_flag_reg) begin
      ptr_reg <= pic_off_t'(ptr_reg + 7'h01);
    end
  end

  // Location 0 of every page is the page pointer itself
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      page_reg <= PAGE_RESET;
    end else if (wr_done && ptr_reg == PAGE_IND_OFF) begin
      page_reg <= sh_next;
    end
  end

  // Register storage; slot 0 of each bank is shadowed by the page pointer
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      for (int k = 0; k < REG_COUNT; k++) begin
        regs_reg[k] <= REG_RESET;
      end
    end else if (wr_done && ptr_reg != PAGE_IND_OFF) begin
      regs_reg[reg_idx] <= sh_next;
    end
  end

  // Link sequencer, clocked only by the link clock
  always_ff @(posedge link_clk_i) begin
    if (link_rst || !i2c_en_reg) begin
      st_reg <= D_IDLE;
      after_reg <= D_IDLE;
      bcnt_reg <= 3'h0;
      tx_reg <= 8'h00;
      sda_oe_n_reg <= 1'h1;
    end else if (start_ev) begin
      st_reg <= D_ADDR;
      bcnt_reg <= 3'h0;
      sda_oe_n_reg <= 1'h1;
    end else if (stop_ev) begin
      st_reg <= D_IDLE;
      sda_oe_n_reg <= 1'h1;
    end else begin
      case (st_reg)
        D_ADDR, D_MAP, D_WDATA: begin
          if (rise_ev) begin
            bcnt_reg <= 3'(bcnt_reg + 3'h1);
            if (last_bit) begin
              if (st_reg == D_ADDR && !addr_hit) begin
                st_reg <= D_IDLE;
              end else begin
                st_reg <= D_RXACK;
                after_reg <= (st_reg != D_ADDR) ? D_WDATA :
                             (sh_next[0] ? D_RDATA : D_MAP);
              end
            end
          end
        end
        D_RXACK: begin
          if (fall_ev) begin
            if (bcnt_reg == 3'h0) begin
              sda_oe_n_reg <= 1'h0;
              bcnt_reg <= 3'h1;
            end else begin
              bcnt_reg <= 3'h0;
              st_reg <= after_reg;
              tx_reg <= rd_byte;
              sda_oe_n_reg <= (after_reg == D_RDATA) ? rd_byte[7] : 1'h1;
            end
          end
        end
        D_RDATA: begin
          if (fall_ev) begin
            sda_oe_n_reg <= tx_reg[7];
          end else if (rise_ev) begin
            tx_reg <= {tx_reg[6:0], 1'h0};
            bcnt_reg <= 3'(bcnt_reg + 3'h1);
            if (last_bit) begin
              st_reg <= D_RACK;
            end
          end
        end
        D_RACK: begin
          if (fall_ev) begin
            sda_oe_n_reg <= 1'h1;
          end else if (rise_ev) begin
            // Host acknowledge asks for the next byte, a NACK ends the read
            if (!sda_f) begin
              st_reg <= D_RDATA;
              tx_reg <= rd_byte;
              bcnt_reg <= 3'h0;
            end else begin
              st_reg <= D_IDLE;
            end
          end
        end
        default: begin
          st_reg <= D_IDLE;
          sda_oe_n_reg <= 1'h1;
        end
      endcase
    end
  end
  assign link.dev_sda_oe_n = sda_oe_n_reg;
  assign link.dev_sda_out = 1'h0;  // Open drain: only ever pulls low

  // Hold words stay put for a whole byte time, far longer than the crossing
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      h_page_reg <= PAGE_RESET;
      h_off_reg <= PAGE_IND_OFF;
      h_data_reg <= 8'h00;
      h_tgl_reg <= 1'h0;
    end else if (wr_done) begin
      h_page_reg <= (ptr_reg == PAGE_IND_OFF) ? sh_next : page_reg;
      h_off_reg <= ptr_reg;
      h_data_reg <= sh_next;
      h_tgl_reg <= ~h_tgl_reg;
    end
  end

  pic_sync #(.WIDTH(1)) u_core_sync (
    .clk_i(clk_i),
    .d_i(h_tgl_reg),
    .q_o(core_tgl_s)
  );

  // Core side: a toggle change publishes one register write
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      core_tgl_q_reg <= 1'h0;
      wr_strobe_o <= 1'h0;
      wr_page_o <= PAGE_RESET;
      wr_offset_o <= PAGE_IND_OFF;
      wr_data_o <= 8'h00;
    end else begin
      core_tgl_q_reg <= core_tgl_s;
      wr_strobe_o <= core_tgl_s ^ core_tgl_q_reg;
      if (core_tgl_s ^ core_tgl_q_reg) begin
        wr_page_o <= h_page_reg;
        wr_offset_o <= h_off_reg;
        wr_data_o <= h_data_reg;
      end
    end
  end
endmodule : pic_device
`default_nettype wire

//--- rtl/pic_host.sv
// Paged I2C control port: host end, byte engine behind AHB-Lite registers
`default_nettype none
module pic_host #(
  parameter int POWERUP_WAIT = pic_pkg::POWERUP_WAIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  pic_if.host link
);
  import pic_pkg::*;

  logic sda_s;
  logic ap_take;
  logic dp_wr_reg;
  logic [HOST_AW-1:0] dp_addr_reg;
  logic cmd_go;
  logic [31:0] stat_word;
  logic [31:0] rd_mux;
  logic [31:0] pwr_cnt_reg;
  logic pwr_ok_reg;
  logic [15:0] div_reg;
  logic [15:0] div_cnt_reg;
  logic tick;
  logic busy;
  pic_host_state_t st_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_reg;
  pic_byte_t tx_reg;
  pic_byte_t rx_reg;
  logic nack_reg;
  logic stop_f_reg;
  logic read_f_reg;
  logic nack_f_reg;
  logic scl_oe_n_reg;
  logic sda_oe_n_reg;

  pic_sync #(.WIDTH(1)) u_sda_sync (
    .clk_i(clk_i),
    .d_i(link.sda),
    .q_o(sda_s)
  );

  // Bus decode; hsize is always a word here and is not checked
  assign busy = (st_reg != H_IDLE);
  assign ap_take = hsel_i && htrans_i[1] && hready_i;
  assign cmd_go = dp_wr_reg && (dp_addr_reg == HOST_CMD_OFF) && !busy && pwr_ok_reg;
  always_comb begin
    stat_word = 32'h0;
    stat_word[STAT_BUSY_BIT] = busy;
    stat_word[STAT_NACK_BIT] = nack_reg;
    stat_word[STAT_RX_LSB +: 8] = rx_reg;
    stat_word[STAT_PWR_BIT] = pwr_ok_reg;
  end
  assign rd_mux = (haddr_i[HOST_AW-1:0] == HOST_STAT_OFF) ? stat_word :
                  (haddr_i[HOST_AW-1:0] == HOST_DIV_OFF) ? {16'h0, div_reg} : 32'h0;

  // Zero wait states: read data is ready for the data phase
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dp_wr_reg <= 1'h0;
      dp_addr_reg <= '0;
      hrdata_o <= 32'h0;
      hreadyout_o <= 1'h1;
      hresp_o <= 1'h0;
      div_reg <= QUARTER_SM;
    end else begin
      dp_wr_reg <= ap_take && hwrite_i;
      dp_addr_reg <= haddr_i[HOST_AW-1:0];
      if (ap_take && !hwrite_i) begin
        hrdata_o <= rd_mux;
      end
      if (dp_wr_reg && dp_addr_reg == HOST_DIV_OFF) begin
        div_reg <= hwdata_i[15:0];
      end
    end
  end

  // Hold off transfers until supplies have settled
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pwr_cnt_reg <= 32'h0;
      pwr_ok_reg <= 1'h0;
    end else if (pwr_cnt_reg >= 32'(POWERUP_WAIT - 1)) begin
      pwr_ok_reg <= 1'h1;
    end else begin
      pwr_cnt_reg <= pwr_cnt_reg + 32'h1;
    end
  end

  // Quarter-bit divider runs only during a transfer, so idle lines stay still
  assign tick = busy && (div_cnt_reg >= div_reg);
  always_ff @(posedge clk_i) begin
    if (reset_i || !busy || tick) begin
      div_cnt_reg <= 16'h1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h1;
    end
  end

  // Byte engine: four quarters per bit, SDA moves while SCL is low except at Start and Stop
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= H_IDLE;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      nack_reg <= 1'h0;
      stop_f_reg <= 1'h0;
      read_f_reg <= 1'h0;
      nack_f_reg <= 1'h0;
      scl_oe_n_reg <= 1'h1;
      sda_oe_n_reg <= 1'h1;
    end else if (cmd_go) begin
      st_reg <= hwdata_i[CMD_START_BIT] ? H_START : H_BIT;
      tx_reg <= hwdata_i[7:0];
      stop_f_reg <= hwdata_i[CMD_STOP_BIT];
      read_f_reg <= hwdata_i[CMD_READ_BIT];
      nack_f_reg <= hwdata_i[CMD_NACK_BIT];
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
    end else if (tick) begin
      q_reg <= 2'(q_reg + 2'h1);
      case (st_reg)
        H_START: begin
          case (q_reg)
            2'h0: sda_oe_n_reg <= 1'h1;
            2'h1: scl_oe_n_reg <= 1'h1;
            2'h2: sda_oe_n_reg <= 1'h0;
            default: begin
              scl_oe_n_reg <= 1'h0;
              st_reg <= H_BIT;
            end
          endcase
        end
        H_BIT: begin
          case (q_reg)
            2'h0: begin
              if (bit_reg[3]) begin
                sda_oe_n_reg <= read_f_reg ? nack_f_reg : 1'h1;
              end else begin
                sda_oe_n_reg <= read_f_reg | tx_reg[7];
              end
            end
            2'h1: scl_oe_n_reg <= 1'h1;
            2'h2: begin
              if (bit_reg[3]) begin
                nack_reg <= read_f_reg ? 1'h0 : sda_s;
              end else begin
                rx_reg <= {rx_reg[6:0], sda_s};
              end
            end
            default: begin
              scl_oe_n_reg <= 1'h0;
              tx_reg <= {tx_reg[6:0], 1'h0};
              bit_reg <= 4'(bit_reg + 4'h1);
              if (bit_reg[3]) begin
                st_reg <= stop_f_reg ? H_STOP : H_IDLE;
              end
            end
          endcase
        end
        H_STOP: begin
          case (q_reg)
            2'h0: sda_oe_n_reg <= 1'h0;
            2'h1: scl_oe_n_reg <= 1'h1;
            2'h2: sda_oe_n_reg <= 1'h1;
            default: st_reg <= H_IDLE;
          endcase
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end
  assign link.host_scl_oe_n = scl_oe_n_reg;
  assign link.host_sda_oe_n = sda_oe_n_reg;
  assign link.host_scl_out = 1'h0;
  assign link.host_sda_out = 1'h0;
endmodule : pic_host
`default_nettype wire

//--- bench/pic_assertions.sv
// Link protocol checker for the paged I2C control port
`default_nettype none
module pic_assertions #(
  parameter logic [1:0] STRAP = 2'h2
) (
  input wire logic link_clk_i,
  input wire logic reset_i,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  import pic_pkg::*;
  logic scl_q, sda_q, first, rw, dead, idle;
  logic [3:0] bits;
  logic [7:0] sh;
  // Line events as seen on the link clock
  wire start = scl_q & scl & sda_q & ~sda;
  wire stop = scl_q & scl & ~sda_q & sda;
  wire rise = ~scl_q & scl;
  wire ack_bit = rise & (bits == 4'h8);
  wire miss = sh[7:1] != {CHIP_ADDR_HI, STRAP};
  // Previous line levels, for edge detection
  always_ff @(posedge link_clk_i) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  // Nine clock rises per byte, the last one is the acknowledge
  always_ff @(posedge link_clk_i) begin
    if (reset_i || start) begin
      bits <= 4'h0;
    end else if (rise) begin
      bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
    end
  end
  // Received byte; the acknowledge bit is not shifted in
  always_ff @(posedge link_clk_i) begin
    if (rise && bits != 4'h8) begin
      sh <= {sh[6:0], sda};
    end
  end
  // Frame flags: address byte pending, and frames the device must ignore
  always_ff @(posedge link_clk_i) begin
    if (reset_i || start) begin
      first <= 1'b1;
      dead <= 1'b0;
    end else if (ack_bit) begin
      first <= 1'b0;
      dead <= dead | (first & miss);
    end
  end
  // Direction is only known once the address byte is complete
  always_ff @(posedge link_clk_i) begin
    if (ack_bit && first) begin
      rw <= sh[0];
    end
  end
  // Bus idle from reset or Stop until the next Start
  always_ff @(posedge link_clk_i) begin
    idle <= reset_i | stop | (idle & ~start);
  end
  default clocking cb @(posedge link_clk_i); endclocking
  default disable iff (reset_i);
  // Device starts an acknowledge, then keeps the line low
  sequence ack_begin;
    $fell(dev_sda_oe_n) && (first || !rw);
  endsequence
  sequence ack_held;
    !dev_sda_oe_n [*8];
  endsequence
  sda_hold_a: assert property (
    $changed(dev_sda_oe_n) |-> !scl && !$past(scl))
    else $error("device data changed while clock high");
  host_edge_a: assert property (
    $changed(host_sda_oe_n) && scl && $past(scl) |-> start || stop)
    else $error("host data changed while clock high");
  match_ack_a: assert property (
    ack_bit && first && !miss |-> !sda)
    else $error("own address not acknowledged");
  nomatch_nack_a: assert property (
    ack_bit && first && miss |-> sda)
    else $error("foreign address acknowledged");
  ignore_frame_a: assert property (
    dead |-> dev_sda_oe_n)
    else $error("device drove data in an ignored frame");
  write_ack_a: assert property (
    ack_bit && !first && !rw && !dead |-> !sda)
    else $error("written byte not acknowledged");
  ack_window_a: assert property (
    ack_begin |-> bits == 4'h8 && !scl ##1 ack_held)
    else $error("acknowledge out of place or too short");
  read_release_a: assert property (
    ack_bit && !first && rw |-> dev_sda_oe_n)
    else $error("device held data during host acknowledge");
  line_idle_a: assert property (
    idle |-> scl && (sda || start))
    else $error("lines not static while idle");
endmodule : pic_assertions
`default_nettype wire

//--- bench/paged_i2c_control_port_bench.sv
// Bench: host end drives device end over the two-wire link
`default_nettype none
module paged_i2c_control_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import pic_pkg::*;
  logic clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, mark = 1'b0, dp = 1'b0;
  logic strap_lsb = 1'b0, strap_msb = 1'b1, sel = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, wr_strobe, hresp;
  logic [7:0] wr_page, wr_data, d0, d2;
  logic [6:0] wr_offset;
  logic [15:0] div;
  logic [63:0] rx;
  logic [63:0] rq[$];
  logic [31:0] wq[$];
  int seed = 32'h2728;
  int miscompares = 0, comparisons = 0, cycles = 0;
  // Core clock, and a link clock with an unrelated phase
  always #4 clk_i = ~clk_i;
  initial begin
    #27;
    forever #80 link_clk_i = ~link_clk_i;
  end
  pic_if link_if();
  pic_host #(.POWERUP_WAIT(50)) pic_host_i (
    .clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hreadyout), .hwdata_i(hwdata),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .link(link_if.host));
  pic_device pic_device_i (
    .link_clk_i(link_clk_i), .clk_i(clk_i), .reset_i(reset_i), .control_path_select_i(sel),
    .address_strap_lsb_i(strap_lsb), .address_strap_msb_i(strap_msb), .link(link_if.device),
    .wr_page_o(wr_page), .wr_offset_o(wr_offset), .wr_data_o(wr_data), .wr_strobe_o(wr_strobe));
  pic_assertions #(.STRAP(2'h2)) pic_assertions_i (
    .link_clk_i(link_clk_i), .reset_i(reset_i), .host_sda_oe_n(link_if.host_sda_oe_n),
    .dev_sda_oe_n(link_if.dev_sda_oe_n), .scl(link_if.scl), .sda(link_if.sda));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  // One single-word transfer; the address phase is held until ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic m);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    mark <= m;
    @(posedge clk_i);
    while (hreadyout !== 1'b1) @(posedge clk_i);
    htrans <= 2'h0;
    mark <= 1'b0;
    hwdata <= d;
    @(posedge clk_i);
    while (hreadyout !== 1'b1) @(posedge clk_i);
    rd = hrdata;
  endtask : bus
  // Note the masked expectation, then read; the watcher compares
  task automatic expect_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rq.push_back({m, e});
    bus(1'b0, a, 32'h0, 1'b1);
  endtask : expect_rd
  // One link byte {nack, read, stop, start, byte}; busy is polled, never assumed
  task automatic cmd(input logic [11:0] c);
    bus(1'b1, HOST_CMD_OFF, {20'h0, c}, 1'b0);
    do bus(1'b0, HOST_STAT_OFF, 32'h0, 1'b0); while (rd[STAT_BUSY_BIT]);
  endtask : cmd
  // Data phase tracking and the hang limit
  always @(posedge clk_i) begin
    dp <= hsel & htrans[1] & ~hwrite & mark & hreadyout;
    cycles <= cycles + 1;
    if (cycles == 98000) begin
      miscompares++;
      test_done();
    end
  end
  // Watcher: results are taken mid-cycle, where they have settled
  always @(negedge clk_i) begin
    if (dp) begin
      rx = rq.pop_front();
      check((hrdata & rx[63:32]) | {31'h0, hresp}, rx[31:0]);
    end
    if (wr_strobe) check({9'h0, wr_page, wr_offset, wr_data}, wq.pop_front());
  end
  initial begin
    repeat (8) @(posedge link_clk_i);
    @(posedge clk_i);
    reset_i <= 1'b0;
    // Divider reset value, an unmapped word, power-up wait, divider write
    expect_rd(HOST_DIV_OFF, 32'hffff, {16'h0, QUARTER_SM});
    expect_rd(8'h0c, 32'hffff_ffff, 32'h0);
    do bus(1'b0, HOST_STAT_OFF, 32'h0, 1'b0); while (!rd[STAT_PWR_BIT]);
    div = 16'h00c8 + {13'h0, 3'($random(seed))};
    bus(1'b1, HOST_DIV_OFF, {16'h0, div}, 1'b0);
    expect_rd(HOST_DIV_OFF, 32'hffff, {16'h0, div});
    // Straps and path select move after capture; the device must ignore both
    repeat (6) @(posedge link_clk_i);
    @(posedge clk_i);
    strap_lsb <= 1'b1;
    strap_msb <= 1'b0;
    sel <= 1'b1;
    $display("test registers done");
    // Increment write across 0x7f to page 2, which shares bank 0 with page 0
    d0 = 8'($random(seed));
    // Odd d2 lands in the speed register, so later frames run a shorter filter
    d2 = 8'($random(seed)) | 8'h01;
    cmd({4'h1, CHIP_ADDR_HI, 2'h2, 1'b0});
    expect_rd(HOST_STAT_OFF, 32'h2, 32'h0);
    cmd({4'h0, 8'hff});
    wq.push_back({9'h0, PAGE_RESET, 7'h7f, d0});
    cmd({4'h0, d0});
    wq.push_back({9'h0, 8'h02, 7'h00, 8'h02});
    cmd({4'h0, 8'h02});
    wq.push_back({9'h0, 8'h02, 7'h01, d2});
    cmd({4'h2, d2});
    $display("test wrap write done");
    // Pointer-only preamble, then a read that wraps to the page indicator
    cmd({4'h1, CHIP_ADDR_HI, 2'h2, 1'b0});
    cmd({4'h2, 8'hff});
    cmd({4'h1, CHIP_ADDR_HI, 2'h2, 1'b1});
    expect_rd(HOST_STAT_OFF, 32'h2, 32'h0);
    cmd({4'h4, 8'hff});
    expect_rd(HOST_STAT_OFF, 32'hff00, {16'h0, d0, 8'h0});
    cmd({4'he, 8'hff});
    expect_rd(HOST_STAT_OFF, 32'hff00, 32'h0200);
    $display("test wrap read done");
    // Address built from the current strap levels must be ignored
    cmd({4'h3, CHIP_ADDR_HI, 2'h1, 1'b0});
    expect_rd(HOST_STAT_OFF, 32'h2, 32'h2);
    $display("test foreign address done");
    check(32'(wq.size() + rq.size()), 32'h0);
    repeat (4) @(posedge clk_i);
    test_done();
  end
endmodule : paged_i2c_control_port_bench
`default_nettype wire
